// ---- rtl/flag_pkg.sv ----
package flag_pkg;
  localparam logic [7:0] timer_flags_offset  = 8'h24;
  localparam logic [7:0] charger_flags_offset = 8'h25;
  localparam logic [7:0] fault0_flags_offset = 8'h26;
  localparam logic [7:0] fault1_flags_offset = 8'h27;
  localparam logic [7:0] flags_reset         = 8'h00;
  localparam int finish_timer_bit     = 0;
  localparam int batt_low_boost_bit   = 4;
  localparam int therm_cold_bit       = 3;
  localparam int therm_cool_bit       = 2;
  localparam int therm_warm_bit       = 1;
  localparam int therm_hot_bit        = 0;
  localparam int sys_short_bit        = 7;
  localparam int sys_overvolt_bit     = 6;
  localparam int boost_overvolt_bit   = 5;
  localparam int boost_undervolt_bit  = 4;
  localparam int thermal_shutdown_bit = 2;
  localparam logic [7:0] timer_used_mask   = 8'h01;
  localparam logic [7:0] charger_used_mask = 8'h1f;
  localparam logic [7:0] fault0_used_mask  = 8'hff;
  localparam logic [7:0] fault1_used_mask  = 8'hf4;
endpackage

// ---- rtl/charger_event_fault_flags.sv ----
// Contract
// - Timer register bit 0 sets on rising edge of finish timer expiry.
// - Charger register bit 4 sets when battery too low for boost output.
// - Charger register bit 3 sets on thermistor cold threshold crossing.
// - Charger register bit 2 sets on thermistor cool threshold crossing.
// - Charger register bit 1 sets on thermistor warm threshold crossing.
// - Charger register bit 0 sets on thermistor hot threshold crossing.
// - Fault0 bit 7 sets on entering and on leaving battery current regulation.
// - Fault0 bit 6 sets on entering input bus over-voltage protection.
// - Fault0 bit 5 sets on entering battery over-voltage protection.
// - Fault0 bit 4 sets on entering input bus over-current protection.
// - Fault0 bit 3 sets on entering battery discharge over-current.
// - Fault0 bit 2 sets on entering converter over-current protection.
// - Fault0 bit 1 sets on entering adapter two over-voltage.
// - Fault0 bit 0 sets on entering adapter one over-voltage.
// - Fault1 bit 7 sets when switching stops for system rail short.
// - Fault1 bit 6 sets when switching stops for system rail over-voltage.
// - Fault1 bit 5 sets when boost output stops on high bus voltage.
// - Fault1 bit 4 sets when boost output stops on low bus voltage.
// - Fault1 bit 2 sets on rising thermal shutdown signal.
// - Flags reset to zero, reserved bits read zero, all read-only.
module charger_event_fault_flags (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       finish_timer_expired,
  input  wire logic       battery_low_for_boost_out,
  input  wire logic       therm_cold_cross,
  input  wire logic       therm_cool_cross,
  input  wire logic       therm_warm_cross,
  input  wire logic       therm_hot_cross,
  input  wire logic       batt_current_reg_change,
  input  wire logic       bus_overvolt_fault,
  input  wire logic       batt_overvolt_fault,
  input  wire logic       bus_overcurrent_fault,
  input  wire logic       batt_discharge_overcurrent,
  input  wire logic       converter_overcurrent,
  input  wire logic       adapter_two_overvolt,
  input  wire logic       adapter_one_overvolt,
  input  wire logic       system_rail_short,
  input  wire logic       system_rail_overvolt,
  input  wire logic       boost_out_overvolt,
  input  wire logic       boost_out_undervolt,
  input  wire logic       thermal_shutdown_event,
  input  wire logic       read_strobe,
  input  wire logic [7:0] read_addr,
  output logic      [7:0] read_data,
  output logic            read_valid
);

  // Event inputs come from analog detectors outside this clock domain.
  logic [19:0] raw;
  logic [19:0] sync_a;
  logic [19:0] sync_b;
  logic [19:0] prev;
  logic [19:0] rise;
  logic [19:0] fall;

  // Bit 0 is a spare slot so that event n sits at index n.
  assign raw[0]  = 1'b0;
  assign raw[1]  = finish_timer_expired;
  assign raw[2]  = battery_low_for_boost_out;
  assign raw[3]  = therm_cold_cross;
  assign raw[4]  = therm_cool_cross;
  assign raw[5]  = therm_warm_cross;
  assign raw[6]  = therm_hot_cross;
  assign raw[7]  = batt_current_reg_change;
  assign raw[8]  = bus_overvolt_fault;
  assign raw[9]  = batt_overvolt_fault;
  assign raw[10] = bus_overcurrent_fault;
  assign raw[11] = batt_discharge_overcurrent;
  assign raw[12] = converter_overcurrent;
  assign raw[13] = adapter_two_overvolt;
  assign raw[14] = adapter_one_overvolt;
  assign raw[15] = system_rail_short;
  assign raw[16] = system_rail_overvolt;
  assign raw[17] = boost_out_overvolt;
  assign raw[18] = boost_out_undervolt;
  assign raw[19] = thermal_shutdown_event;

  // Two stages settle the asynchronous levels before any logic reads them.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= '0;
    end else begin
      sync_a <= raw;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync_b <= '0;
    end else begin
      sync_b <= sync_a;
    end
  end

  // Prev idles low after reset, so an idle low input shows no false edge.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= '0;
    end else begin
      prev <= sync_b;
    end
  end

  // Every event bit gets the same detector; only one flag uses the fall.
  for (genvar i = 0; i < 20; i++) begin : g_edge
    assign rise[i] = sync_b[i] & ~prev[i];
    assign fall[i] = ~sync_b[i] & prev[i];
  end

  logic [7:0] set_timer;
  logic [7:0] set_charger;
  logic [7:0] set_fault0;
  logic [7:0] set_fault1;

  always_comb begin
    set_timer = 8'h00;
    set_timer[flag_pkg::finish_timer_bit] = rise[1];
  end

  always_comb begin
    set_charger = 8'h00;
    set_charger[flag_pkg::batt_low_boost_bit] = rise[2];
    set_charger[flag_pkg::therm_cold_bit]     = rise[3];
    set_charger[flag_pkg::therm_cool_bit]     = rise[4];
    set_charger[flag_pkg::therm_warm_bit]     = rise[5];
    set_charger[flag_pkg::therm_hot_bit]      = rise[6];
  end

  always_comb begin
    set_fault0    = 8'h00;
    set_fault0[7] = rise[7] | fall[7];
    set_fault0[6] = rise[8];
    set_fault0[5] = rise[9];
    set_fault0[4] = rise[10];
    set_fault0[3] = rise[11];
    set_fault0[2] = rise[12];
    set_fault0[1] = rise[13];
    set_fault0[0] = rise[14];
  end

  always_comb begin
    set_fault1 = 8'h00;
    set_fault1[flag_pkg::sys_short_bit]        = rise[15];
    set_fault1[flag_pkg::sys_overvolt_bit]     = rise[16];
    set_fault1[flag_pkg::boost_overvolt_bit]   = rise[17];
    set_fault1[flag_pkg::boost_undervolt_bit]  = rise[18];
    set_fault1[flag_pkg::thermal_shutdown_bit] = rise[19];
  end

  logic [7:0] timer_event_flags;
  logic [7:0] charger_event_flags_three;
  logic [7:0] fault_event_flags_zero;
  logic [7:0] fault_event_flags_one;
  logic [7:0] next_timer_flags;
  logic [7:0] next_charger_flags;
  logic [7:0] next_fault0_flags;
  logic [7:0] next_fault1_flags;
  logic       rd_timer;
  logic       rd_charger;
  logic       rd_fault0;
  logic       rd_fault1;

  // The decoder ignores the address unless a strobe is present.
  always_comb begin
    rd_timer   = 1'b0;
    rd_charger = 1'b0;
    rd_fault0  = 1'b0;
    rd_fault1  = 1'b0;
    if (read_strobe) begin
      case (read_addr)
        flag_pkg::timer_flags_offset: begin
          rd_timer = 1'b1;
        end
        flag_pkg::charger_flags_offset: begin
          rd_charger = 1'b1;
        end
        flag_pkg::fault0_flags_offset: begin
          rd_fault0 = 1'b1;
        end
        flag_pkg::fault1_flags_offset: begin
          rd_fault1 = 1'b1;
        end
        default: begin
          rd_timer = 1'b0;
        end
      endcase
    end
  end

  // A set in the read cycle survives so the event is reported next read.
  // Reserved bits are masked so they can never read back as one.
  always_comb begin
    next_timer_flags = timer_event_flags;
    if (rd_timer) begin
      next_timer_flags = 8'h00;
    end
    next_timer_flags = (next_timer_flags | set_timer)
                       & flag_pkg::timer_used_mask;
  end

  always_comb begin
    next_charger_flags = charger_event_flags_three;
    if (rd_charger) begin
      next_charger_flags = 8'h00;
    end
    next_charger_flags = (next_charger_flags | set_charger)
                         & flag_pkg::charger_used_mask;
  end

  always_comb begin
    next_fault0_flags = fault_event_flags_zero;
    if (rd_fault0) begin
      next_fault0_flags = 8'h00;
    end
    next_fault0_flags = (next_fault0_flags | set_fault0)
                        & flag_pkg::fault0_used_mask;
  end

  always_comb begin
    next_fault1_flags = fault_event_flags_one;
    if (rd_fault1) begin
      next_fault1_flags = 8'h00;
    end
    next_fault1_flags = (next_fault1_flags | set_fault1)
                        & flag_pkg::fault1_used_mask;
  end

  // Besides a read, only power-on reset ever clears a flag.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timer_event_flags <= flag_pkg::flags_reset;
    end else begin
      timer_event_flags <= next_timer_flags;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      charger_event_flags_three <= flag_pkg::flags_reset;
    end else begin
      charger_event_flags_three <= next_charger_flags;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fault_event_flags_zero <= flag_pkg::flags_reset;
    end else begin
      fault_event_flags_zero <= next_fault0_flags;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fault_event_flags_one <= flag_pkg::flags_reset;
    end else begin
      fault_event_flags_one <= next_fault1_flags;
    end
  end

  logic [7:0] selected;

  // Unmapped addresses answer zero and clear nothing.
  always_comb begin
    selected = 8'h00;
    case (read_addr)
      flag_pkg::timer_flags_offset: begin
        selected = timer_event_flags;
      end
      flag_pkg::charger_flags_offset: begin
        selected = charger_event_flags_three;
      end
      flag_pkg::fault0_flags_offset: begin
        selected = fault_event_flags_zero;
      end
      flag_pkg::fault1_flags_offset: begin
        selected = fault_event_flags_one;
      end
      default: begin
        selected = 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      read_valid <= 1'b0;
    end else begin
      read_valid <= read_strobe;
    end
  end

  // Read data holds until the next strobe; there is no write path at all.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      read_data <= 8'h00;
    end else if (read_strobe) begin
      read_data <= selected;
    end
  end

endmodule // charger_event_fault_flags

// ---- tb/flag_host.sv ----
module flag_host (
  input  wire logic       mclk,
  output logic            read_strobe,
  output logic      [7:0] read_addr,
  input  wire logic [7:0] read_data,
  input  wire logic       read_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    read_strobe = 1'b0;
    read_addr   = 8'h00;
  end
  // The strobe lasts one cycle; the address is then inverted, not left stale.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    read_strobe <= 1'b1;
    read_addr   <= a;
    @(posedge mclk);
    read_strobe <= 1'b0;
    read_addr   <= ~a;
    @(posedge mclk);
    ok = (read_valid === 1'b1);
    d  = read_data;
  endtask
endmodule // flag_host

// ---- tb/flag_monitor.sv ----
module flag_monitor (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       thermal_shutdown_event,
  input  wire logic       read_strobe,
  input  wire logic [7:0] read_addr,
  input  wire logic [7:0] read_data,
  input  wire logic       read_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_ANSWER: assert property (read_strobe |=> read_valid)
    else $error("no answer to a read");
  AST_PULSE: assert property (!read_strobe |=> !read_valid)
    else $error("answer without a read");
  AST_HOLD:
    assert property (!read_strobe |=> $stable(read_data))
    else $error("read data moved");
  AST_RSV_CHARGER:
    assert property (read_strobe && read_addr == 8'h25
      |=> read_data[7:5] == 3'h0)
    else $error("reserved charger bits set");
  AST_RSV_FAULT:
    assert property (read_strobe && read_addr == 8'h27
      |=> read_data[3] == 1'b0 && read_data[1:0] == 2'h0)
    else $error("reserved fault bits set");
  AST_RSV_TIMER:
    assert property (read_strobe && read_addr == 8'h24
      |=> read_data[7:1] == 7'h00)
    else $error("reserved timer bits set");
  AST_UNMAPPED:
    assert property (read_strobe && read_addr[7:2] != 6'h09
      |=> read_data == 8'h00)
    else $error("unmapped read not zero");
  AST_SHUTDOWN:
    assert property ($rose(thermal_shutdown_event) ##1 (!read_strobe)[*5] ##1
      (read_strobe && read_addr == 8'h27) |=> read_data[2])
    else $error("shutdown flag lost");
endmodule // flag_monitor
bind charger_event_fault_flags flag_monitor u_mon (.mclk(mclk),
  .reset_n(reset_n),
  .thermal_shutdown_event(thermal_shutdown_event), .read_strobe(read_strobe),
  .read_addr(read_addr), .read_data(read_data), .read_valid(read_valid));

// ---- tb/charger_event_fault_flags_tb_top.sv ----
module charger_event_fault_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [18:0] ev = '0;
  logic [18:0] v;
  logic        read_strobe, read_valid;
  logic  [7:0] read_addr, read_data;
  int          err_total = 0;
  int          checks_done = 0;
  int          seed = 64;
  always #5 mclk = ~mclk;
  charger_event_fault_flags DUT (.mclk(mclk), .reset_n(reset_n),
    .finish_timer_expired(ev[0]), .battery_low_for_boost_out(ev[1]),
    .therm_cold_cross(ev[2]), .therm_cool_cross(ev[3]),
    .therm_warm_cross(ev[4]), .therm_hot_cross(ev[5]),
    .batt_current_reg_change(ev[6]), .bus_overvolt_fault(ev[7]),
    .batt_overvolt_fault(ev[8]), .bus_overcurrent_fault(ev[9]),
    .batt_discharge_overcurrent(ev[10]), .converter_overcurrent(ev[11]),
    .adapter_two_overvolt(ev[12]), .adapter_one_overvolt(ev[13]),
    .system_rail_short(ev[14]), .system_rail_overvolt(ev[15]),
    .boost_out_overvolt(ev[16]), .boost_out_undervolt(ev[17]),
    .thermal_shutdown_event(ev[18]), .read_strobe(read_strobe),
    .read_addr(read_addr), .read_data(read_data), .read_valid(read_valid));
  flag_host HOST (.mclk(mclk), .read_strobe(read_strobe),
    .read_addr(read_addr), .read_data(read_data), .read_valid(read_valid));
  function automatic logic [7:0] flags_of(input logic [7:0] a,
                                          input logic [18:0] e);
    case (a)
      8'h24: return {7'h00, e[0]};
      8'h25: return {3'h0, e[1], e[2], e[3], e[4], e[5]};
      8'h26: return {e[6], e[7], e[8], e[9], e[10], e[11], e[12], e[13]};
      8'h27: return {e[14], e[15], e[16], e[17], 1'b0, e[18], 2'h0};
      default: return 8'h00;
    endcase
  endfunction
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Fault register one is read first so a fresh shutdown event meets no clear.
  task automatic check_all(input logic [18:0] e);
    logic [7:0] a;
    logic [7:0] d;
    bit         ok;
    for (int i = 0; i < 5; i++) begin
      a = 8'h27 - 8'(i);
      HOST.rd(a, d, ok);
      checks_done++;
      if (!ok) begin
        err_total++;
        $display("MISMATCH at %0t: no answer", $time);
        end_of_test();
      end
      if (d !== flags_of(a, e)) begin
        err_total++;
        $display("MISMATCH at %0t: addr %h got %h", $time, a, d);
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    check_all('0);
    for (int k = 0; k < 24; k++) begin
      v = (k == 0) ? '1 : 19'($random(seed));
      ev <= v;
      repeat (6) @(posedge mclk);
      check_all(v);
      check_all('0);
      ev <= '0;
      repeat (6) @(posedge mclk);
      check_all(v & 19'h00040);
    end
    end_of_test();
  end
endmodule // charger_event_fault_flags_tb_top
